// *** rtl/byte_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides and a fill count.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Fill side
   input wire logic inValid,
   input wire logic [WIDTH-1:0] inData,
   output logic inReady,
   // Drain side
   output logic outValid,
   output logic [WIDTH-1:0] outData,
   input wire logic outReady,
   // Fill level
   output logic [$clog2(DEPTH):0] count
);
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 4 || (1 << AW) != DEPTH)
      begin : g_bad_depth
         $error("byte_fifo depth must be a power of two, at least 4");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wrPtr_q;
   logic [AW:0] rdPtr_q;
   logic push;
   logic pop;

   assign count = wrPtr_q - rdPtr_q;
   assign inReady = (count != (AW+1)'(DEPTH));
   assign outValid = (count != '0);
   assign outData = mem[rdPtr_q[AW-1:0]];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_ff @(posedge clock)
   begin
      if (push)
      begin
         mem[wrPtr_q[AW-1:0]] <= inData;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end
      else
      begin
         if (push)
         begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (pop)
         begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
      end
   end
endmodule

// *** rtl/mgmt_ingress_tag_decoder.sv ***
// Management port ingress tag decoder with APB control registers.
// Assumes the receive MAC and forwarding logic share the core clock.
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
`include "mgmt_tag_map.svh"

// Behaviour
// - Opcode 000 frames are forwarded by ordinary address lookup.
// - Opcode 000: class 28-26, enforcement 25-24, bits 23-0 reserved.
// - The tag's three-bit class becomes the forwarding class in both modes.
// - Enforcement 00 normal, 01 untag, 10 tag, 11 reserved and not sent.
// - Opcode 001 adds timestamp request bit 23 and port map bits 8-0.
// - Opcode 001 frames go to every port set in the map, no lookup.
// - Map bit 8 is the management port; bits 5-0 are front ports.
// - Timestamp request asks for the egress transmit time reported back.
// - Tag octets arrive most significant first.
// - With tagging disabled, management port frames are treated untagged.
// - Pause frames carry no tag and pass as ordinary frames.
module mgmt_ingress_tag_decoder #(
   parameter int FIFO_DEPTH = 8
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Receive stream from the management port MAC
   input wire logic rxValid,
   input wire logic [7:0] rxData,
   input wire logic rxLast,
   output logic rxReady,
   // Frame stream to forwarding, tag removed
   output logic txValid,
   output logic [7:0] txData,
   output logic txLast,
   input wire logic txReady,
   // Forwarding decision, one pulse per frame
   output logic descValid,
   output mgmt_tag_pkg::descriptor_t desc
);
   localparam int CW = $clog2(FIFO_DEPTH) + 1;
   localparam logic [CW-1:0] ROOM = CW'(FIFO_DEPTH - 3);

   generate
      if (FIFO_DEPTH < 4)
      begin : g_bad_depth
         $error("FIFO_DEPTH below 4 leaves no room for the pause replay");
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Tag decoding
   // ----------------------------------------------------------------------
   function automatic mgmt_tag_pkg::descriptor_t decodeTag(input logic [31:0] tag);
      mgmt_tag_pkg::descriptor_t d;
      logic [2:0] opcode;
      logic isLookup;
      logic isDirect;
      opcode = tag[`MT_OPC_LSB +: 3];
      isLookup = (opcode == `MT_OPC_LOOKUP);
      isDirect = (opcode == `MT_OPC_DIRECT);
      d.byLookup = isLookup;
      d.forwardClass = tag[`MT_CLS_LSB +: 3];
      d.tagEnforce = tag[`MT_ENF_LSB +: 2];
      d.timestampRequest = isDirect && tag[`MT_TSR_BIT];
      // Reserved bits 7:6 and 22:9 never reach the decision
      d.egressPortMap = isDirect ? (tag[`MT_MAP_LSB +: 9] & `MT_PORT_MASK) : 9'h000;
      d.drop = !(isLookup || isDirect) || (d.tagEnforce == `MT_ENF_RSVD);
      return d;
   endfunction

   // ----------------------------------------------------------------------
   // Registers and APB state
   // ----------------------------------------------------------------------
   logic [31:0] ctrl_q, frames_q, drops_q, tsReq_q;
   logic [31:0] prdata_d, prdata_q;
   logic pready_q, pslverr_q;
   logic mapped, apbSetup, apbDone;

   // ----------------------------------------------------------------------
   // Parser state
   // ----------------------------------------------------------------------
   mgmt_tag_pkg::parse_t state_q;
   mgmt_tag_pkg::parse_t state_d;
   logic [3:0] byteCount_q;
   logic [31:0] tag_q;
   logic accept;
   logic rxReady_q;
   logic descValid_q;
   mgmt_tag_pkg::descriptor_t desc_q;
   mgmt_tag_pkg::descriptor_t plainDesc;
   logic [31:0] tagNext;
   logic isPause;

   // ----------------------------------------------------------------------
   // Buffer signals
   // ----------------------------------------------------------------------
   mgmt_tag_pkg::stream_byte_t pushByte;
   mgmt_tag_pkg::stream_byte_t popByte;
   logic pushValid, fifoInReady, fifoOutValid, fifoOutReady;
   logic [CW-1:0] fifoCount;
   logic txValid_q, txLast_q;
   logic [7:0] txData_q;

   // ----------------------------------------------------------------------
   // APB slave: answers in the first access cycle
   // ----------------------------------------------------------------------
   assign apbSetup = psel && !penable && !pready_q;
   assign apbDone = psel && penable && pready_q;

   always_comb
   begin
      mapped = 1'b1;
      prdata_d = 32'h0000_0000;
      case (paddr)
         `MT_REG_CTRL:
            prdata_d = {28'h000_0000, ctrl_q[3:0]};
         `MT_REG_LAST:
            prdata_d = {15'h0000, desc_q};
         `MT_REG_FRAMES:
            prdata_d = frames_q;
         `MT_REG_DROPS:
            prdata_d = drops_q;
         `MT_REG_TSREQ:
            prdata_d = tsReq_q;
         default:
            mapped = 1'b0;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         pready_q <= apbSetup;
         pslverr_q <= apbSetup && !mapped;
         prdata_q <= (apbSetup && !pwrite) ? prdata_d : 32'h0000_0000;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         ctrl_q <= `MT_CTRL_RESET;
      else if (apbDone && pwrite && paddr == `MT_REG_CTRL)
         ctrl_q <= {28'h000_0000, pwdata[3:0]};
   end

   // ----------------------------------------------------------------------
   // Parser next state
   // ----------------------------------------------------------------------
   assign accept = rxValid && rxReady_q;
   assign tagNext = {tag_q[23:0], rxData};
   assign isPause = ({tag_q[7:0], rxData} == `MT_PAUSE_TYPE);
   assign plainDesc = decodeTag({`MT_OPC_LOOKUP, ctrl_q[`MT_CTRL_CLS_LSB +: 3], 26'h000_0000});

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         mgmt_tag_pkg::S_ADDR:
         begin
            if (accept && rxLast)
               state_d = mgmt_tag_pkg::S_ADDR;
            else if (accept && byteCount_q == `MT_ADDR_BYTES - 4'h1)
               state_d = ctrl_q[`MT_CTRL_TAG_EN] ? mgmt_tag_pkg::S_TAG
                  : mgmt_tag_pkg::S_BODY;
         end
         mgmt_tag_pkg::S_TAG:
         begin
            if (accept && rxLast)
               state_d = mgmt_tag_pkg::S_ADDR;
            else if (accept && byteCount_q == `MT_ADDR_BYTES + 4'h1 && isPause)
               state_d = mgmt_tag_pkg::S_REPLAY_HI;
            else if (accept && byteCount_q == `MT_TAG_LAST)
               state_d = mgmt_tag_pkg::S_BODY;
         end
         mgmt_tag_pkg::S_REPLAY_HI:
            if (fifoInReady)
               state_d = mgmt_tag_pkg::S_REPLAY_LO;
         mgmt_tag_pkg::S_REPLAY_LO:
            if (fifoInReady)
               state_d = mgmt_tag_pkg::S_BODY;
         mgmt_tag_pkg::S_BODY:
            if (accept && rxLast)
               state_d = mgmt_tag_pkg::S_ADDR;
         default:
            state_d = mgmt_tag_pkg::S_ADDR;
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         state_q <= mgmt_tag_pkg::S_ADDR;
      else
         state_q <= state_d;
   end

   // Input stalls during replay and when the buffer is close to full
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         rxReady_q <= 1'b0;
      else
         rxReady_q <= (state_d != mgmt_tag_pkg::S_REPLAY_HI)
            && (state_d != mgmt_tag_pkg::S_REPLAY_LO) && (fifoCount <= ROOM);
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         byteCount_q <= 4'h0;
         tag_q <= 32'h0000_0000;
      end
      else if (accept)
      begin
         byteCount_q <= (rxLast || byteCount_q == `MT_TAG_LAST) ? 4'h0 : byteCount_q + 4'h1;
         if (state_q == mgmt_tag_pkg::S_TAG)
            tag_q <= tagNext;
      end
   end

   // ----------------------------------------------------------------------
   // Forwarding decision
   // ----------------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         descValid_q <= 1'b0;
         desc_q <= '0;
      end
      else
      begin
         descValid_q <= 1'b0;
         if (accept && rxLast
            && (state_q == mgmt_tag_pkg::S_ADDR || state_q == mgmt_tag_pkg::S_TAG))
         begin
            // Runt that ended before its decision
            descValid_q <= 1'b1;
            desc_q <= '{drop: 1'b1, default: '0};
         end
         else if (accept && state_q == mgmt_tag_pkg::S_ADDR && state_d == mgmt_tag_pkg::S_BODY)
         begin
            descValid_q <= 1'b1;
            desc_q <= plainDesc;
         end
         else if (accept && state_d == mgmt_tag_pkg::S_REPLAY_HI)
         begin
            descValid_q <= 1'b1;
            desc_q <= plainDesc;
         end
         else if (accept && state_q == mgmt_tag_pkg::S_TAG && byteCount_q == `MT_TAG_LAST)
         begin
            descValid_q <= 1'b1;
            desc_q <= decodeTag(tagNext);
         end
      end
   end

   // Statistics for software
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         frames_q <= 32'h0000_0000;
         drops_q <= 32'h0000_0000;
         tsReq_q <= 32'h0000_0000;
      end
      else if (descValid_q)
      begin
         frames_q <= frames_q + 32'h0000_0001;
         drops_q <= drops_q + {31'h0000_0000, desc_q.drop};
         tsReq_q <= tsReq_q + {31'h0000_0000, desc_q.timestampRequest};
      end
   end

   // ----------------------------------------------------------------------
   // Frame data path: tag bytes held back, pause type replayed
   // ----------------------------------------------------------------------
   always_comb
   begin
      pushValid = 1'b0;
      pushByte.data = rxData;
      pushByte.last = rxLast;
      case (state_q)
         mgmt_tag_pkg::S_ADDR, mgmt_tag_pkg::S_BODY:
            pushValid = accept;
         mgmt_tag_pkg::S_REPLAY_HI:
         begin
            pushValid = 1'b1;
            pushByte.data = tag_q[15:8];
            pushByte.last = 1'b0;
         end
         mgmt_tag_pkg::S_REPLAY_LO:
         begin
            pushValid = 1'b1;
            pushByte.data = tag_q[7:0];
            pushByte.last = 1'b0;
         end
         default:
            pushValid = 1'b0;
      endcase
   end

   byte_fifo #(
      .WIDTH($bits(mgmt_tag_pkg::stream_byte_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_buffer (
      .clock(clock),
      .rst_n(rst_n),
      .inValid(pushValid),
      .inData(pushByte),
      .inReady(fifoInReady),
      .outValid(fifoOutValid),
      .outData(popByte),
      .outReady(fifoOutReady),
      .count(fifoCount)
   );

   assign fifoOutReady = !txValid_q || txReady;

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         txValid_q <= 1'b0;
         txData_q <= 8'h00;
         txLast_q <= 1'b0;
      end
      else if (fifoOutReady)
      begin
         txValid_q <= fifoOutValid;
         txData_q <= popByte.data;
         txLast_q <= popByte.last;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign rxReady = rxReady_q;
   assign txValid = txValid_q;
   assign txData = txData_q;
   assign txLast = txLast_q;
   assign descValid = descValid_q;
   assign desc = desc_q;
endmodule

// *** shared/mgmt_tag_map.svh ***
// Offsets, field positions, reset values and framing counts of the
// management tag decoder. Definitions only; included by bare name.
`ifndef MGMT_TAG_MAP_SVH
`define MGMT_TAG_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define MT_REG_CTRL 8'h00
`define MT_REG_LAST 8'h04
`define MT_REG_FRAMES 8'h08
`define MT_REG_DROPS 8'h0C
`define MT_REG_TSREQ 8'h10

// ----------------------------------------------------------------------
// Control fields and reset value
// ----------------------------------------------------------------------
`define MT_CTRL_TAG_EN 0
`define MT_CTRL_CLS_LSB 1
`define MT_CTRL_RESET 32'h0000_0001

// ----------------------------------------------------------------------
// Tag fields
// ----------------------------------------------------------------------
`define MT_OPC_LSB 29
`define MT_CLS_LSB 26
`define MT_ENF_LSB 24
`define MT_TSR_BIT 23
`define MT_MAP_LSB 0
`define MT_OPC_LOOKUP 3'h0
`define MT_OPC_DIRECT 3'h1
`define MT_ENF_RSVD 2'h3
`define MT_PORT_MASK 9'h13F

// ----------------------------------------------------------------------
// Framing counts
// ----------------------------------------------------------------------
`define MT_ADDR_BYTES 4'hC
`define MT_TAG_LAST 4'hF
`define MT_PAUSE_TYPE 16'h8808

`endif

// *** shared/mgmt_tag_pkg.sv ***
// Types shared by the management tag decoder and its stream buffer.
// Assumes nothing of its surroundings.
package mgmt_tag_pkg;

   // Parse position within a received frame
   typedef enum logic [2:0]
   {
      S_ADDR,
      S_TAG,
      S_REPLAY_HI,
      S_REPLAY_LO,
      S_BODY
   } parse_t;

   // One frame byte with its end marker
   typedef struct packed
   {
      logic [7:0] data;
      logic last;
   } stream_byte_t;

   // Forwarding decision for one frame
   typedef struct packed
   {
      logic drop;
      logic byLookup;
      logic [2:0] forwardClass;
      logic [1:0] tagEnforce;
      logic timestampRequest;
      logic [8:0] egressPortMap;
   } descriptor_t;

endpackage

// *** verif/cpu_frame_source.sv ***
// CPU side model feeding frames into the receive stream.
// Assumes a byte is taken at an edge with rxValid and rxReady high.
`timescale 1ns/1ps
module cpu_frame_source
(
   // Clock
   input wire logic clock,
   // Receive stream
   output logic rxValid,
   output logic [7:0] rxData,
   output logic rxLast,
   input wire logic rxReady
);
   initial
   begin
      rxValid = 1'b0;
      rxData = 8'h00;
      rxLast = 1'b0;
   end

   // Address bytes, tag octets, then body
   function automatic logic [7:0] byte_at(input logic [31:0] tag, input int i);
      if (i < 12)
         return 8'(i + 16);
      if (i < 16)
         return tag[31 - 8 * (i - 12) -: 8];
      return 8'(i);
   endfunction

   task automatic send(input logic [31:0] tag, input int len, input int gap);
      for (int i = 0; i < len; i++)
      begin
         rxValid <= 1'b1;
         rxData <= byte_at(tag, i);
         rxLast <= (i == len - 1);
         @(posedge clock);
         while (rxReady !== 1'b1)
            @(posedge clock);
         if (gap > 0 || i == len - 1)
         begin
            // Released data line shows no stale byte
            rxValid <= 1'b0;
            rxData <= ~rxData;
            rxLast <= 1'b0;
            repeat (gap > 0 ? gap : 1) @(posedge clock);
         end
      end
   endtask
endmodule

// *** verif/mgmt_tag_sva.sv ***
// Port checker for the management tag decoder.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module mgmt_tag_sva #(
   parameter int FIFO_DEPTH = 8
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Transmit stream
   input wire logic txValid,
   input wire logic [7:0] txData,
   input wire logic txLast,
   input wire logic txReady,
   // Descriptor
   input wire logic descValid,
   input wire mgmt_tag_pkg::descriptor_t desc
);
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   sequence apbSetup;
      psel && !penable && !pready;
   endsequence
   sequence txStall;
      txValid && !txReady;
   endsequence

   a_setup_answer: assert property (apbSetup |=> pready)
      else $error("no answer after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   a_desc_pulse: assert property (descValid |=> !descValid)
      else $error("descriptor pulse too long");
   a_desc_holds: assert property (!descValid |-> $stable(desc))
      else $error("descriptor changed without pulse");
   a_lookup_nomap: assert property (descValid && desc.byLookup |-> desc.egressPortMap == 9'h000)
      else $error("lookup frame carries a port map");
   a_map_ports: assert property (descValid |-> (desc.egressPortMap & 9'h0C0) == 9'h000)
      else $error("map names absent ports");
   a_enf_legal: assert property (descValid && !desc.drop |-> desc.tagEnforce != 2'h3)
      else $error("reserved enforcement forwarded");
   a_tx_hold: assert property (txStall |=> txValid && $stable({txData, txLast}))
      else $error("stalled byte not held");
endmodule

bind mgmt_ingress_tag_decoder mgmt_tag_sva #(.FIFO_DEPTH(FIFO_DEPTH)) sva_u (.clock, .rst_n,
   .psel, .penable, .prdata, .pready, .pslverr, .txValid, .txData, .txLast, .txReady,
   .descValid, .desc);

// *** verif/test_mgmt_ingress_tag_decoder.sv ***
// Self-checking bench for the management tag decoder.
// Assumes package, map header, checker and CPU model are compiled first.
`timescale 1ns/1ps
`include "mgmt_tag_map.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_mgmt_ingress_tag_decoder;
   typedef struct {logic [31:0] tag; int len; logic [16:0] exp; logic [16:0] mask;} row_t;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, txReady = 1'b0, hold = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, rxValid, rxLast, rxReady, txValid, txLast, descValid, err;
   logic [7:0] rxData, txData;
   logic [8:0] txGot;
   mgmt_tag_pkg::descriptor_t desc;
   logic [8:0] expQ[$];
   logic [16:0] descQ[$];
   int n_mismatch = 0, total_checks = 0, cyc = 0, gap = 0, nFrames = 0, nDrops = 0;
   row_t rows[4] = '{
      '{32'h1500_0000, 20, 17'h0D400, 17'h1FFFF},
      '{32'h2E80_013F, 18, 17'h03B3F, 17'h1FFFF},
      '{32'h3C00_00C1, 17, 17'h07001, 17'h1FFFF},
      '{32'h0300_0000, 20, 17'h10000, 17'h10000}};

   always #4 clock = ~clock;

   mgmt_ingress_tag_decoder #(.FIFO_DEPTH(8)) dut_u (.clock, .rst_n, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .rxValid, .rxData, .rxLast, .rxReady,
      .txValid, .txData, .txLast, .txReady, .descValid, .desc);
   cpu_frame_source src_u (.clock, .rxValid, .rxData, .rxLast, .rxReady);

   // Stalling sink and descriptor capture
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      txReady <= !hold && (cyc % 5 != 3);
      if (descValid === 1'b1)
         descQ.push_back(desc);
      if (txValid === 1'b1 && txReady === 1'b1)
      begin
         txGot = expQ.size() ? expQ.pop_front() : 9'h1FF;
         `CHK("tx", txGot, {txData, txLast})
      end
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int t;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      t = 0;
      @(posedge clock);
      while (pready !== 1'b1 && t < 20)
      begin
         @(posedge clock);
         t++;
      end
      if (pready !== 1'b1)
         n_mismatch++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask

   task automatic run(input logic [31:0] tag, input int len, input bit strip,
      input logic [16:0] exp, input logic [16:0] mask);
      logic [16:0] got;
      int w;
      for (int i = 0; i < len; i++)
         if (!strip || i < 12 || i > 15)
            expQ.push_back({src_u.byte_at(tag, i), i == len - 1});
      nFrames++;
      nDrops += exp[16];
      src_u.send(tag, len, gap);
      w = 0;
      while (descQ.size() == 0 && w < 40)
      begin
         @(posedge clock);
         w++;
      end
      got = descQ.size() ? descQ.pop_front() : ~exp;
      `CHK("desc", exp & mask, got & mask)
   endtask

   initial
   begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      give_verdict();
   end

   initial
   begin
      repeat (10) @(posedge clock);
      `CHK("rxReady", 1'b0, rxReady)
      rst_n <= 1'b1;
      @(posedge clock);
      apb(1'b0, `MT_REG_CTRL, 32'h0);
      `CHK("ctrl", `MT_CTRL_RESET, rd)
      apb(1'b1, `MT_REG_CTRL, 32'hFFFF_FFFF);
      apb(1'b0, `MT_REG_CTRL, 32'h0);
      `CHK("ctrl", 32'h0000_000F, rd)
      apb(1'b1, `MT_REG_LAST, 32'hFFFF_FFFF);
      `CHK("ro", 1'b0, err)
      apb(1'b0, 8'h14, 32'h0);
      `CHK("unmapped", 33'h1_0000_0000, {err, rd})
      apb(1'b1, `MT_REG_CTRL, 32'h0000_000D);
      foreach (rows[k])
         run(rows[k].tag, rows[k].len, 1'b1, rows[k].exp, rows[k].mask);
      gap = 2;
      for (int op = 2; op < 8; op++)
         run({3'(op), 29'h0}, 20, 1'b1, 17'h10000, 17'h10000);
      run(32'h8808_0000, 20, 1'b0, 17'h0E000, 17'h1FFFF);
      apb(1'b1, `MT_REG_CTRL, 32'h0000_000C);
      run(32'h2E80_013F, 20, 1'b0, 17'h0E000, 17'h1FFFF);
      apb(1'b1, `MT_REG_CTRL, 32'h0000_0001);
      run(32'h2000_0000, 12, 1'b0, 17'h10000, 17'h1FFFF);
      gap = 0;
      hold <= 1'b1;
      fork
         run(32'h0000_0000, 40, 1'b1, 17'h08000, 17'h1FFFF);
         begin
            repeat (40) @(posedge clock);
            `CHK("full", 1'b0, rxReady)
            hold <= 1'b0;
         end
      join
      repeat (60) @(posedge clock);
      `CHK("drained", 0, expQ.size())
      apb(1'b0, `MT_REG_FRAMES, 32'h0);
      `CHK("frames", 32'(nFrames), rd)
      apb(1'b0, `MT_REG_DROPS, 32'h0);
      `CHK("drops", 32'(nDrops), rd)
      apb(1'b0, `MT_REG_TSREQ, 32'h0);
      `CHK("tsreq", 32'h0000_0001, rd)
      give_verdict();
   end
endmodule
